// ==== rtl/timer_event_counter_control.v ====
// Timer/event counter control and status with Avalon-MM register access.
// Assumes timer_io pad is resolved outside from pin_out/pin_oe; one clock domain.
`timescale 1ns/1ps
`include "timer_event_counter_defs.vh"
module timer_event_counter_control (
  input wire sys_clk,
  input wire rst_b,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire pin_in,
  output reg pin_out,
  output reg pin_oe,
  output reg timer_irq
);
  reg rst_meta;
  reg rst_sync_b;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  reg timer_run_enable;
  reg count_done_irq_enable;
  reg polarity_invert;
  reg [2:0] timer_op_select;
  reg pin_general_io_select;
  reg count_done_flag;
  reg pin_direction;
  reg pin_input_value;
  reg pin_output_value;
  reg [`CNT_W-1:0] reload_capture_value;
  reg [`CNT_W-1:0] counter;
  reg run_d;
  reg half_phase;
  reg at_zero;
  reg [1:0] pulse_cnt;
  reg pin_s1;
  reg pin_s2;
  reg pin_s3;
  reg pin_level;
  reg pin_level_d;
  reg done_d;

  wire gpio_active = pin_general_io_select && (timer_op_select == `OP_MODE0);
  wire ext_clock = (timer_op_select == `OP_MODE6) || (timer_op_select == `OP_MODE7);
  wire internal_clock = (timer_op_select == `OP_MODE0) || (timer_op_select == `OP_MODE1);
  // Active edge taken from filtered level; inversion picks falling edge
  wire ext_edge = polarity_invert ? (pin_level_d && !pin_level) : (!pin_level_d && pin_level);
  wire event_tick = internal_clock ? half_phase : (ext_clock ? ext_edge : 1'b0);
  wire bus_req = (avs_read || avs_write) && avs_waitrequest;
  // Writes land at the edge where the master sees waitrequest low, not at the edge that takes them
  wire wr_done = avs_write && !avs_waitrequest;
  wire wr_cs = wr_done && (avs_address == `ADDR_CONTROL_STATUS);
  wire rd_cs = avs_read && avs_waitrequest && (avs_address == `ADDR_CONTROL_STATUS);
  wire wr_ctl = wr_done && (avs_address == `ADDR_CONTROL);
  wire sw_reset = wr_ctl && avs_writedata[`BIT_SW_RESET];
  wire irq_ack = wr_ctl && avs_writedata[`BIT_IRQ_ACK];
  wire start = timer_run_enable && !run_d;
  wire terminal = timer_run_enable && !start && at_zero && event_tick;

  // Pin input: three flops, a change counts when stages two and three agree
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_s3 <= 1'b1;
      pin_level <= 1'b1;
      pin_level_d <= 1'b1;
    end else begin
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pin_level <= pin_s3;
      end
      pin_level_d <= pin_level;
    end
  end

  // Register file and control bits
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      timer_run_enable <= 1'b0;
      count_done_irq_enable <= 1'b0;
      polarity_invert <= 1'b0;
      timer_op_select <= 3'h0;
      pin_general_io_select <= 1'b0;
      pin_direction <= 1'b0;
      pin_output_value <= 1'b0;
      reload_capture_value <= `CNT_ZERO;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      // One wait state: waitrequest drops for one cycle per request
      avs_waitrequest <= !bus_req;
      if (sw_reset) begin
        timer_run_enable <= 1'b0;
        count_done_irq_enable <= 1'b0;
        polarity_invert <= 1'b0;
        timer_op_select <= 3'h0;
        pin_general_io_select <= 1'b0;
        pin_direction <= 1'b0;
        pin_output_value <= 1'b0;
      end else if (wr_cs) begin
        timer_run_enable <= avs_writedata[`BIT_RUN];
        count_done_irq_enable <= avs_writedata[`BIT_IRQ_EN];
        polarity_invert <= avs_writedata[`BIT_INV];
        timer_op_select <= avs_writedata[`BIT_OP_HI:`BIT_OP_LO];
        pin_general_io_select <= avs_writedata[`BIT_GPIO];
        pin_direction <= avs_writedata[`BIT_DIR];
        pin_output_value <= avs_writedata[`BIT_DOUT];
      end
      if (wr_done && avs_address == `ADDR_RELOAD) begin
        reload_capture_value <= avs_writedata[`CNT_W-1:0];
      end
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `ADDR_CONTROL_STATUS: begin
            // Upper bits stay zero
            avs_readdata <= {21'h000000, pin_output_value, pin_input_value, pin_direction, count_done_flag,
                             pin_general_io_select, timer_op_select, polarity_invert, count_done_irq_enable,
                             timer_run_enable};
          end
          `ADDR_RELOAD: avs_readdata <= {8'h00, reload_capture_value};
          `ADDR_COUNTER: avs_readdata <= {8'h00, counter};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Counter, done flag, pulse and pin drive
  always @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      counter <= `CNT_ZERO;
      run_d <= 1'b0;
      half_phase <= 1'b0;
      at_zero <= 1'b0;
      count_done_flag <= 1'b0;
      pulse_cnt <= 2'h0;
      pin_input_value <= 1'b1;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      timer_irq <= 1'b0;
      done_d <= 1'b0;
    end else begin
      run_d <= timer_run_enable;
      done_d <= terminal;
      if (!timer_run_enable || start) begin
        half_phase <= 1'b0;
      end else begin
        half_phase <= !half_phase;
      end
      if (start) begin
        counter <= reload_capture_value;
        at_zero <= 1'b0;
      end else if (timer_run_enable && event_tick) begin
        if (at_zero) begin
          counter <= reload_capture_value;
          at_zero <= 1'b0;
        end else begin
          counter <= counter - `CNT_ONE;
          at_zero <= (counter == `CNT_ONE) || (counter == `CNT_ZERO);
        end
      end
      // Set wins over a read or ack clear in the same cycle; software reset wins over set
      if (sw_reset) begin
        count_done_flag <= 1'b0;
      end else if (terminal) begin
        count_done_flag <= 1'b1;
      end else if (rd_cs || irq_ack) begin
        count_done_flag <= 1'b0;
      end
      timer_irq <= count_done_flag && count_done_irq_enable && !sw_reset;
      if (sw_reset) begin
        pin_input_value <= 1'b1;
      end else begin
        pin_input_value <= pin_level ^ polarity_invert;
      end
      if (terminal && timer_op_select == `OP_MODE1) begin
        pulse_cnt <= `PULSE_CYCLES;
      end else if (pulse_cnt != 2'h0) begin
        pulse_cnt <= pulse_cnt - 2'h1;
      end
      if (gpio_active) begin
        pin_oe <= pin_direction;
        pin_out <= pin_output_value ^ polarity_invert;
      end else if (timer_op_select == `OP_MODE1 && timer_run_enable) begin
        pin_oe <= 1'b1;
        pin_out <= (pulse_cnt != 2'h0) ^ polarity_invert;
      end else begin
        pin_oe <= 1'b0;
        pin_out <= 1'b0;
      end
    end
  end
endmodule // timer_event_counter_control

// ==== rtl/timer_event_counter_defs.vh ====
// Constants for the timer/event counter control block.
// Assumes a 20 MHz sys_clk and an Avalon-MM slave with 32-bit data.
// Contract
// - op select field chooses clock, pin, mode
// - Both resets clear op select
// - External pin clock synchronised before counting
// - Modes six, seven external; four, five input
// - GPIO only when bit set, mode zero
// - Both resets clear GPIO select
// - Done flag set at terminal count
// - Done flag cleared by read, ack, reset
// - Direction bit: zero input, one output
// - Direction ignored when mode non-zero
// - Input bit shows pin, optionally inverted
// - Both resets set input bit
// - GPIO output drives output bit, optionally inverted
// - Output bit inert outside GPIO; reset clears
// - Bits eleven to twenty-three read zero
// - Mode zero loads, decrements every two clocks
// - Terminal count sets flag, interrupts, reloads
// - Mode one emits two-clock pulse
// - Run enable loads counter and starts
// - Irq enable gates terminal-count interrupts
// - Invert flips output, selects falling edge
// - Counter is 24 bits wide
`ifndef TIMER_EVENT_COUNTER_DEFS_VH
`define TIMER_EVENT_COUNTER_DEFS_VH
`define ADDR_CONTROL_STATUS 3'h0
`define ADDR_RELOAD 3'h1
`define ADDR_COUNTER 3'h2
`define ADDR_CONTROL 3'h3
`define BIT_RUN 0
`define BIT_IRQ_EN 1
`define BIT_INV 2
`define BIT_OP_LO 3
`define BIT_OP_HI 5
`define BIT_GPIO 6
`define BIT_DONE 7
`define BIT_DIR 8
`define BIT_DIN 9
`define BIT_DOUT 10
`define BIT_SW_RESET 0
`define BIT_IRQ_ACK 1
`define OP_MODE0 3'h0
`define OP_MODE1 3'h1
`define OP_MODE6 3'h6
`define OP_MODE7 3'h7
`define CNT_W 24
`define CNT_ZERO 24'h000000
`define CNT_ONE 24'h000001
`define PULSE_CYCLES 2'h2
`endif

// ==== bench/timer_pin_source.sv ====
// Far-side model of the timer pin: an outside source behind a pull-up.
// Assumes the bench sets ext_level; the device wins while pin_oe is high.
`timescale 1ns/1ps
module timer_pin_source (
  input wire pin_out,
  input wire pin_oe,
  input wire ext_level,
  output wire pin_in
);
  // Bench paces ext_level well below a quarter of sys_clk
  assign pin_in = pin_oe ? pin_out : ext_level;
endmodule // timer_pin_source

// ==== bench/timer_event_counter_control_monitor.sv ====
// Port checker for the timer control block.
// Assumes it is bound to the design top; one clock domain.
`timescale 1ns/1ps
module timer_event_counter_control_monitor (
  input wire sys_clk,
  input wire rst_b,
  input wire [2:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire pin_out,
  input wire pin_oe,
  input wire timer_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire wr0 = avs_write && !avs_waitrequest && avs_address == 3'h0;
  wire rd0 = avs_read && !avs_waitrequest && avs_address == 3'h0;
  wire gpio_lvl = avs_writedata[10] ^ avs_writedata[2];
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_answer; $rose(avs_read) |=> s_answer; endproperty
  a_answer: assert property (p_answer) else $error("read answer not one cycle");
  property p_rsv; rd0 |-> avs_readdata[31:11] == 21'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_hold; timer_irq && avs_waitrequest && $past(avs_waitrequest) |=> timer_irq; endproperty
  a_hold: assert property (p_hold) else $error("irq dropped without cause");
  property p_rdclr; rd0 && timer_irq |-> ##[1:3] !timer_irq; endproperty
  a_rdclr: assert property (p_rdclr) else $error("read did not clear irq");
  property p_gpio_out; wr0 && avs_writedata[8:3] == 6'h28 |-> ##2 pin_oe && pin_out == $past(gpio_lvl, 2); endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("gpio output wrong");
  property p_no_drive; wr0 && (avs_writedata[5] || avs_writedata[6:3] == 4'h0) |-> ##2 !pin_oe; endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven when it must not be");
  property p_oe_cause; $rose(pin_oe) |-> $past(avs_write) || $past(avs_write, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin drive began without a write");
  property p_irq_off; wr0 && !avs_writedata[1] |-> ##2 !timer_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
endmodule // timer_event_counter_control_monitor
bind timer_event_counter_control timer_event_counter_control_monitor mon (.sys_clk(sys_clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_out(pin_out), .pin_oe(pin_oe),
  .timer_irq(timer_irq));

// ==== bench/timer_event_counter_control_tb.sv ====
// Bench for the timer control block: Avalon-MM tasks and scenario calls.
// Assumes the pin source model and the bound port checker.
`timescale 1ns/1ps
module timer_event_counter_control_tb;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [2:0] avs_address = 3'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg ext_level = 1'b1;
  reg [31:0] rv;
  reg [31:0] wd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, pin_in, pin_out, pin_oe, timer_irq;
  integer fail_count = 0, checks = 0, cyc = 0, t0, i, j;
  timer_event_counter_control dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .timer_irq(timer_irq));
  timer_pin_source far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // Starts after a rising edge so a release and a new request never share a time step
  // Waits for the answer with no cycle limit of its own; the bench ceiling ends a hang
  task bus(input rw, input [2:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !rw;
      avs_write <= rw;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0) begin
        @(posedge sys_clk);
      end
      rv = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task idle(input integer k);
    repeat (k) @(posedge sys_clk);
  endtask
  // Bounded wait on pin_out (which=1) or timer_irq (which=0)
  task wait_sig(input integer which, input lvl);
    integer n;
    begin
      n = 0;
      while ((which ? pin_out : timer_irq) !== lvl && n < 200) begin
        @(posedge sys_clk);
        n = n + 1;
      end
      if (n == 200) fail_count = fail_count + 1;
    end
  endtask
  initial begin
    idle(16);
    rst_b <= 1'b1;
    idle(4);
    bus(0, 3'h0, 32'h0);
    chk(rv, 32'h200);
    bus(0, 3'h5, 32'h0);
    chk(rv, 32'h0);
    bus(1, 3'h0, 32'hfff804);
    idle(8);
    bus(0, 3'h0, 32'h0);
    chk(rv, 32'h4);
    for (i = 0; i < 4; i = i + 1) begin
      wd = 32'h140 | (i[0] << 10) | (i[1] << 2);
      bus(1, 3'h0, wd);
      idle(8);
      @(negedge sys_clk);
      chk(pin_out, i[0] ^ i[1]);
      bus(0, 3'h0, 32'h0);
      chk(rv, wd | (i[0] << 9));
    end
    bus(1, 3'h0, 32'h130);
    idle(3);
    @(negedge sys_clk);
    chk(pin_oe, 0);
    bus(1, 3'h0, 32'h140);
    bus(1, 3'h0, 32'h500);
    idle(3);
    @(negedge sys_clk);
    chk(pin_oe, 0);
    chk(pin_out, 0);
    ext_level <= 1'b0;
    bus(1, 3'h0, 32'h40);
    idle(8);
    bus(0, 3'h0, 32'h0);
    chk(rv, 32'h40);
    ext_level <= 1'b1;
    bus(1, 3'h1, 32'h9);
    bus(1, 3'h0, 32'h3);
    wait_sig(0, 1);
    t0 = cyc;
    bus(0, 3'h0, 32'h0);
    chk(rv, 32'h283);
    idle(1);
    @(negedge sys_clk);
    chk(timer_irq, 0);
    wait_sig(0, 1);
    chk(cyc - t0, 20);
    bus(1, 3'h3, 32'h2);
    idle(1);
    @(negedge sys_clk);
    chk(timer_irq, 0);
    bus(1, 3'h0, 32'h1);
    idle(30);
    @(negedge sys_clk);
    chk(timer_irq, 0);
    bus(0, 3'h0, 32'h0);
    chk(rv, 32'h281);
    for (i = 0; i < 2; i = i + 1) begin
      bus(1, 3'h0, 32'h0);
      bus(1, 3'h0, 32'h9 | (i[0] << 2));
      idle(4);
      wait_sig(1, !i[0]);
      t0 = cyc;
      wait_sig(1, i[0]);
      chk(cyc - t0, 2);
    end
    bus(1, 3'h1, 32'h2);
    // Rising edges count with inversion clear, falling edges with it set
    for (j = 0; j < 2; j = j + 1) begin
      bus(1, 3'h3, 32'h1);
      bus(1, 3'h0, 32'h3b | (j << 2));
      for (i = 0; i < 3; i = i + 1) begin
        idle(1);
        ext_level <= 1'b0;
        idle(8);
        @(negedge sys_clk);
        chk(timer_irq, j[0] && i == 2);
        idle(1);
        ext_level <= 1'b1;
        idle(8);
        @(negedge sys_clk);
        chk(timer_irq, i == 2);
      end
    end
    bus(1, 3'h3, 32'h1);
    bus(0, 3'h0, 32'h0);
    chk(rv, 32'h200);
    // Hardware reset in mid-run must undo what software set up
    bus(1, 3'h0, 32'h547);
    rst_b <= 1'b0;
    idle(2);
    rst_b <= 1'b1;
    idle(4);
    bus(0, 3'h0, 32'h0);
    chk(rv, 32'h200);
    report_and_stop;
  end
endmodule // timer_event_counter_control_tb
